//--- design/smc_pkg.sv
// Package of constants for the standby mode controller
package smc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_SCR0 = 8'h00;
    localparam logic [7:0] OFS_SCR2 = 8'h04;
    localparam logic [7:0] OFS_IDLE_CFG = 8'h08;
    localparam logic [7:0] OFS_HALT_CMD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // system_control_reg_zero fields
    localparam int SCR0_RSEL_BIT = 0;
    localparam int SCR0_HIGH_EN_BIT = 1;
    localparam int SCR0_LOW_EN_BIT = 2;
    localparam logic [2:0] SCR0_RESET = 3'h2;
    // system_control_reg_two fields
    localparam int SCR2_WARM_LSB = 0;
    localparam int SCR2_DRIVE_BIT = 2;
    localparam int SCR2_MODE_LSB = 3;
    localparam logic [4:0] SCR2_RESET = 5'h02;
    // Halt mode field codes
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_PART_IDLE = 2'h1;
    localparam logic [1:0] MODE_OSC_IDLE = 2'h2;
    localparam logic [1:0] MODE_STOP = 2'h3;
    // Warm-up select codes
    localparam logic [1:0] WARM_SEL_8 = 2'h1;
    localparam logic [1:0] WARM_SEL_14 = 2'h2;
    localparam logic [1:0] WARM_SEL_16 = 2'h3;
    localparam logic [1:0] WARM_SEL_18 = 2'h0;
    // Warm-up lengths in oscillator cycles
    localparam int WARM_LEN_8 = 256;
    localparam int WARM_LEN_14 = 16384;
    localparam int WARM_LEN_16 = 65536;
    localparam int WARM_LEN_18 = 262144;
    localparam int WARM_CNT_W = 19;
    // Oscillator tick dividers, in clk_in cycles
    localparam int HIGH_DIV = 2;
    localparam int LOW_DIV = 8;
    localparam int DIV_W = 8;
    // Status fields
    localparam int STAT_CLK_LOW_BIT = 5;
    localparam int STAT_HIGH_BIT = 6;
    localparam int STAT_LOW_BIT = 7;
    localparam int STAT_WAKE_BIT = 8;
    localparam int STAT_WARM_BIT = 9;
    // Controller states, one-hot
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_PART_IDLE = 5'h02,
        ST_OSC_IDLE = 5'h04,
        ST_STOP = 5'h08,
        ST_WARMUP = 5'h10
    } smc_state_e;
endpackage

//--- design/smc_warmup.sv
// Oscillator warm-up counter for stop release
`timescale 1ns/10ps
module smc_warmup #(
    parameter int WARM_LEN_8 = smc_pkg::WARM_LEN_8,
    parameter int WARM_LEN_14 = smc_pkg::WARM_LEN_14,
    parameter int WARM_LEN_16 = smc_pkg::WARM_LEN_16,
    parameter int WARM_LEN_18 = smc_pkg::WARM_LEN_18
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Control
    input wire logic start_in,
    input wire logic osc_tick_in,
    input wire logic [1:0] sel_in,
    // Result
    output logic busy_out,
    output logic done_out
);
    localparam int CW = smc_pkg::WARM_CNT_W;
    logic [CW-1:0] cnt_r;

    // Length in cycles of the resume oscillator
    function automatic logic [CW-1:0] warm_len(input logic [1:0] sel);
        logic [CW-1:0] len;
        len = WARM_LEN_18[CW-1:0];
        if (sel == smc_pkg::WARM_SEL_8) begin
            len = WARM_LEN_8[CW-1:0];
        end else if (sel == smc_pkg::WARM_SEL_14) begin
            len = WARM_LEN_14[CW-1:0];
        end else if (sel == smc_pkg::WARM_SEL_16) begin
            len = WARM_LEN_16[CW-1:0];
        end
        return len;
    endfunction

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_r <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_r <= warm_len(sel_in);
                busy_out <= 1'b1;
            end else if (busy_out && osc_tick_in) begin
                // Counts only ticks of the resuming oscillator
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == CW'(1)) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule

//--- design/smc_pin_gate.sv
// Port buffer gating during full stop
`timescale 1ns/10ps
module smc_pin_gate #(
    parameter int NGEN = 8,
    parameter int NPU = 4,
    parameter int NLOW = 5
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Control
    input wire logic stop_in,
    input wire logic drive_en_in,
    // Pin directions, 1 = output
    input wire logic [NGEN-1:0] gen_dir_in,
    input wire logic [NPU-1:0] pu_dir_in,
    input wire logic [NLOW-1:0] low_dir_in,
    // Buffer enables
    output logic [NGEN-1:0] gen_oe_out,
    output logic [NGEN-1:0] gen_ie_out,
    output logic [NPU-1:0] pu_oe_out,
    output logic [NPU-1:0] pu_ie_out,
    output logic [NLOW-1:0] low_oe_out,
    output logic [NLOW-1:0] low_ie_out,
    output logic special_ie_out
);
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            gen_oe_out <= '0;
            gen_ie_out <= '0;
            pu_oe_out <= '0;
            pu_ie_out <= '0;
            low_oe_out <= '0;
            low_ie_out <= '0;
            special_ie_out <= 1'b1;
        end else if (!stop_in) begin
            gen_oe_out <= gen_dir_in;
            gen_ie_out <= ~gen_dir_in;
            pu_oe_out <= pu_dir_in;
            pu_ie_out <= ~pu_dir_in;
            low_oe_out <= low_dir_in;
            low_ie_out <= ~low_dir_in;
            special_ie_out <= 1'b1;
        end else begin
            // Outputs keep driving only with drive enabled
            gen_oe_out <= drive_en_in ? gen_dir_in : '0;
            gen_ie_out <= '0;
            pu_oe_out <= drive_en_in ? pu_dir_in : '0;
            // Gate shut so a floating pull-up pin draws no current
            pu_ie_out <= '0;
            low_oe_out <= drive_en_in ? low_dir_in : '0;
            low_ie_out <= drive_en_in ? ~low_dir_in : '0;
            special_ie_out <= 1'b1;
        end
    end
endmodule

//--- design/smc_top.sv
// Standby mode controller: halt states, wake-up, warm-up, stop pin control
// Operation
// - Partial idle stops the CPU; only software-enabled peripherals keep running.
// - Oscillator-only idle stops system clock; oscillator and real-time clock run.
// - Wake requests caught regardless of system clock; release is clock synchronous.
// - Full stop halts every circuit including the oscillator.
// - After full stop release, clock held off until warm-up elapses.
// - Resume select 0 resumes on high clock, 1 on low clock.
// - Warm-up select 01, 10, 11, 00 give 2^8, 2^14, 2^16, 2^18 cycles.
// - Port buffer state in full stop follows the drive enable bit.
// - Drive off: inputs ignored, outputs floating; drive on: outputs keep driving.
// - Pull-up pins: input gate off in stop; drive only as output with drive on.
// - Interrupt, reset, mode, wake pins stay live; low group only with drive on.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module smc_top #(
    parameter int NPERIPH = 8,
    parameter int NGEN = 8,
    parameter int NPU = 4,
    parameter int NLOW = 5,
    parameter int WARM_LEN_8 = smc_pkg::WARM_LEN_8,
    parameter int WARM_LEN_14 = smc_pkg::WARM_LEN_14,
    parameter int WARM_LEN_16 = smc_pkg::WARM_LEN_16,
    parameter int WARM_LEN_18 = smc_pkg::WARM_LEN_18
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Wake-up request from the interrupt logic
    input wire logic wake_req_in,
    // Pin directions, 1 = output
    input wire logic [NGEN-1:0] gen_dir_in,
    input wire logic [NPU-1:0] pu_dir_in,
    input wire logic [NLOW-1:0] low_dir_in,
    // Clock and run controls
    output logic cpu_run_out,
    output logic sys_clk_en_out,
    output logic [NPERIPH-1:0] periph_run_out,
    output logic osc_high_run_out,
    output logic osc_low_run_out,
    output logic rtc_run_out,
    output logic clk_low_sel_out,
    // Pin buffer enables
    output logic [NGEN-1:0] gen_oe_out,
    output logic [NGEN-1:0] gen_ie_out,
    output logic [NPU-1:0] pu_oe_out,
    output logic [NPU-1:0] pu_ie_out,
    output logic [NLOW-1:0] low_oe_out,
    output logic [NLOW-1:0] low_ie_out,
    output logic special_ie_out
);
    ////////
    smc_pkg::smc_state_e state_r, state_nxt;
    logic [2:0] scr0_r;
    logic [4:0] scr2_r;
    logic [NPERIPH-1:0] idle_cfg_r;
    logic wake_seen_r;
    logic osc_high_r, osc_low_r, clk_low_r;
    logic [smc_pkg::DIV_W-1:0] div_high_r, div_low_r;
    logic tick_high_r, tick_low_r;
    logic warm_start_r;
    logic warm_busy, warm_done;
    logic wr_en, rd_en, addr_ok, halt_cmd;
    logic sys_tick, resume_tick;
    logic [1:0] halt_mode;

    // Address decode shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    ////////
    // APB handshake: one wait state, answer on the second access cycle
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && !pready && !pwrite;
    assign halt_mode = scr2_r[smc_pkg::SCR2_MODE_LSB +: 2];
    assign halt_cmd = wr_en && reg_hit(paddr, smc_pkg::OFS_HALT_CMD);

    always_comb begin
        addr_ok = 1'b0;
        if (reg_hit(paddr, smc_pkg::OFS_SCR0) || reg_hit(paddr, smc_pkg::OFS_SCR2)
            || reg_hit(paddr, smc_pkg::OFS_IDLE_CFG) || reg_hit(paddr, smc_pkg::OFS_HALT_CMD)
            || reg_hit(paddr, smc_pkg::OFS_STATUS)) begin
            addr_ok = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= 32'h00000000;
            if (reg_hit(paddr, smc_pkg::OFS_SCR0)) begin
                prdata[2:0] <= scr0_r;
            end else if (reg_hit(paddr, smc_pkg::OFS_SCR2)) begin
                prdata[4:0] <= scr2_r;
            end else if (reg_hit(paddr, smc_pkg::OFS_IDLE_CFG)) begin
                prdata[NPERIPH-1:0] <= idle_cfg_r;
            end else if (reg_hit(paddr, smc_pkg::OFS_STATUS)) begin
                prdata[4:0] <= state_r;
                prdata[smc_pkg::STAT_CLK_LOW_BIT] <= clk_low_r;
                prdata[smc_pkg::STAT_HIGH_BIT] <= osc_high_r;
                prdata[smc_pkg::STAT_LOW_BIT] <= osc_low_r;
                prdata[smc_pkg::STAT_WAKE_BIT] <= wake_seen_r;
                prdata[smc_pkg::STAT_WARM_BIT] <= warm_busy;
            end
        end
    end

    ////////
    // Software registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            scr0_r <= smc_pkg::SCR0_RESET;
            scr2_r <= smc_pkg::SCR2_RESET;
            idle_cfg_r <= '0;
        end else if (wr_en) begin
            if (reg_hit(paddr, smc_pkg::OFS_SCR0)) begin
                scr0_r <= pwdata[2:0];
            end else if (reg_hit(paddr, smc_pkg::OFS_SCR2)) begin
                scr2_r <= pwdata[4:0];
            end else if (reg_hit(paddr, smc_pkg::OFS_IDLE_CFG)) begin
                idle_cfg_r <= pwdata[NPERIPH-1:0];
            end
        end
    end

    ////////
    // Oscillator tick dividers; a stopped oscillator gives no ticks
    function automatic logic [smc_pkg::DIV_W-1:0] div_next(input logic run,
            input logic [smc_pkg::DIV_W-1:0] cnt, input logic [smc_pkg::DIV_W-1:0] last);
        return (!run || cnt == last) ? '0 : cnt + 1'b1;
    endfunction

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_high_r <= '0;
            tick_high_r <= 1'b0;
        end else begin
            div_high_r <= div_next(osc_high_r, div_high_r, smc_pkg::DIV_W'(smc_pkg::HIGH_DIV - 1));
            tick_high_r <= osc_high_r && div_high_r == smc_pkg::DIV_W'(smc_pkg::HIGH_DIV - 1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_low_r <= '0;
            tick_low_r <= 1'b0;
        end else begin
            div_low_r <= div_next(osc_low_r, div_low_r, smc_pkg::DIV_W'(smc_pkg::LOW_DIV - 1));
            tick_low_r <= osc_low_r && div_low_r == smc_pkg::DIV_W'(smc_pkg::LOW_DIV - 1);
        end
    end

    assign sys_tick = clk_low_r ? tick_low_r : tick_high_r;
    assign resume_tick = scr0_r[smc_pkg::SCR0_RSEL_BIT] ? tick_low_r : tick_high_r;

    ////////
    // Wake capture, free of system clock ticks
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wake_seen_r <= 1'b0;
        end else if (state_r == smc_pkg::ST_RUN) begin
            wake_seen_r <= 1'b0;
        end else if (wake_req_in) begin
            wake_seen_r <= 1'b1;
        end
    end

    ////////
    // Halt state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            smc_pkg::ST_RUN: begin
                if (halt_cmd && halt_mode == smc_pkg::MODE_PART_IDLE) begin
                    state_nxt = smc_pkg::ST_PART_IDLE;
                end else if (halt_cmd && halt_mode == smc_pkg::MODE_OSC_IDLE) begin
                    state_nxt = smc_pkg::ST_OSC_IDLE;
                end else if (halt_cmd && halt_mode == smc_pkg::MODE_STOP) begin
                    state_nxt = smc_pkg::ST_STOP;
                end
            end
            smc_pkg::ST_PART_IDLE, smc_pkg::ST_OSC_IDLE: begin
                // Release lands on a system clock tick
                if (wake_seen_r && sys_tick) begin
                    state_nxt = smc_pkg::ST_RUN;
                end
            end
            smc_pkg::ST_STOP: begin
                if (wake_seen_r) begin
                    state_nxt = smc_pkg::ST_WARMUP;
                end
            end
            smc_pkg::ST_WARMUP: begin
                if (warm_done) begin
                    state_nxt = smc_pkg::ST_RUN;
                end
            end
            default: state_nxt = smc_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_r <= smc_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            warm_start_r <= 1'b0;
        end else begin
            warm_start_r <= state_r == smc_pkg::ST_STOP && wake_seen_r;
        end
    end

    ////////
    // Oscillators and clock select
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            osc_high_r <= 1'b1;
            osc_low_r <= 1'b0;
            clk_low_r <= 1'b0;
        end else if (state_nxt == smc_pkg::ST_STOP) begin
            osc_high_r <= 1'b0;
            osc_low_r <= 1'b0;
        end else if (state_r == smc_pkg::ST_STOP && wake_seen_r) begin
            // Resume settings were loaded by software before the halt
            osc_high_r <= scr0_r[smc_pkg::SCR0_HIGH_EN_BIT];
            osc_low_r <= scr0_r[smc_pkg::SCR0_LOW_EN_BIT];
            clk_low_r <= scr0_r[smc_pkg::SCR0_RSEL_BIT];
        end
    end

    // Run enables, registered so each output comes from a flop
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cpu_run_out <= 1'b0;
            sys_clk_en_out <= 1'b0;
            periph_run_out <= '0;
            rtc_run_out <= 1'b0;
            osc_high_run_out <= 1'b0;
            osc_low_run_out <= 1'b0;
            clk_low_sel_out <= 1'b0;
        end else begin
            cpu_run_out <= state_nxt == smc_pkg::ST_RUN;
            sys_clk_en_out <= state_nxt == smc_pkg::ST_RUN
                || state_nxt == smc_pkg::ST_PART_IDLE;
            if (state_nxt == smc_pkg::ST_RUN) begin
                periph_run_out <= '1;
            end else if (state_nxt == smc_pkg::ST_PART_IDLE) begin
                periph_run_out <= idle_cfg_r;
            end else begin
                periph_run_out <= '0;
            end
            rtc_run_out <= state_nxt != smc_pkg::ST_STOP;
            osc_high_run_out <= osc_high_r && state_nxt != smc_pkg::ST_STOP;
            osc_low_run_out <= osc_low_r && state_nxt != smc_pkg::ST_STOP;
            clk_low_sel_out <= clk_low_r;
        end
    end

    ////////
    smc_warmup #(
        .WARM_LEN_8(WARM_LEN_8),
        .WARM_LEN_14(WARM_LEN_14),
        .WARM_LEN_16(WARM_LEN_16),
        .WARM_LEN_18(WARM_LEN_18)
    ) u_warmup (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .start_in(warm_start_r),
        .osc_tick_in(resume_tick),
        .sel_in(scr2_r[smc_pkg::SCR2_WARM_LSB +: 2]),
        .busy_out(warm_busy),
        .done_out(warm_done)
    );

    smc_pin_gate #(
        .NGEN(NGEN),
        .NPU(NPU),
        .NLOW(NLOW)
    ) u_pin_gate (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .stop_in(state_nxt == smc_pkg::ST_STOP),
        .drive_en_in(scr2_r[smc_pkg::SCR2_DRIVE_BIT]),
        .gen_dir_in(gen_dir_in),
        .pu_dir_in(pu_dir_in),
        .low_dir_in(low_dir_in),
        .gen_oe_out(gen_oe_out),
        .gen_ie_out(gen_ie_out),
        .pu_oe_out(pu_oe_out),
        .pu_ie_out(pu_ie_out),
        .low_oe_out(low_oe_out),
        .low_ie_out(low_ie_out),
        .special_ie_out(special_ie_out)
    );
endmodule

//--- tb/smc_top_sva.sv
// Port checker for the standby mode controller
`timescale 1ns/10ps
module smc_top_sva #(
    parameter int NPERIPH = 8,
    parameter int NGEN = 8,
    parameter int NPU = 4,
    parameter int NLOW = 5,
    parameter int WARM_LEN_8 = 256,
    parameter int WARM_LEN_14 = 16384,
    parameter int WARM_LEN_16 = 65536,
    parameter int WARM_LEN_18 = 262144
) (
    // Clock and reset
    input logic clk_in,
    input logic reset_in,
    // APB
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic pslverr,
    // Wake and pin directions
    input logic wake_req_in,
    input logic [NGEN-1:0] gen_dir_in,
    input logic [NPU-1:0] pu_dir_in,
    input logic [NLOW-1:0] low_dir_in,
    // Run controls
    input logic cpu_run_out,
    input logic sys_clk_en_out,
    input logic [NPERIPH-1:0] periph_run_out,
    input logic osc_high_run_out,
    input logic osc_low_run_out,
    input logic rtc_run_out,
    input logic clk_low_sel_out,
    // Buffer enables
    input logic [NGEN-1:0] gen_oe_out,
    input logic [NGEN-1:0] gen_ie_out,
    input logic [NPU-1:0] pu_oe_out,
    input logic [NPU-1:0] pu_ie_out,
    input logic [NLOW-1:0] low_oe_out,
    input logic [NLOW-1:0] low_ie_out,
    input logic special_ie_out
);
    ////////
    // Shadow of written settings; only accepted writes count
    logic [2:0] scr0_r;
    logic [4:0] scr2_r;
    logic from_stop_r;
    int cnt_r;
    int exp_cnt;
    wire wr = psel && penable && pready && pwrite && !pslverr;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            scr0_r <= smc_pkg::SCR0_RESET;
            scr2_r <= smc_pkg::SCR2_RESET;
        end else if (wr && paddr == smc_pkg::OFS_SCR0) begin
            scr0_r <= pwdata[2:0];
        end else if (wr && paddr == smc_pkg::OFS_SCR2) begin
            scr2_r <= pwdata[4:0];
        end
    end
    // Cycles since the stop ended, to time the warm-up
    always_ff @(posedge clk_in) begin
        if (reset_in || !rtc_run_out) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            from_stop_r <= 1'b0;
        end else if ($fell(rtc_run_out)) begin
            from_stop_r <= 1'b1;
        end else if (cpu_run_out) begin
            from_stop_r <= 1'b0;
        end
    end
    always_comb begin
        case (scr2_r[1:0])
            smc_pkg::WARM_SEL_8: exp_cnt = WARM_LEN_8;
            smc_pkg::WARM_SEL_14: exp_cnt = WARM_LEN_14;
            smc_pkg::WARM_SEL_16: exp_cnt = WARM_LEN_16;
            default: exp_cnt = WARM_LEN_18;
        endcase
        exp_cnt = exp_cnt * (scr0_r[0] ? smc_pkg::LOW_DIV : smc_pkg::HIGH_DIV);
    end
    ////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_halt_enter;
        wr && paddr == smc_pkg::OFS_HALT_CMD && cpu_run_out && scr2_r[4:3] != 2'h0
            |=> !cpu_run_out;
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("halt not taken");
    property p_halt_refuse;
        wr && paddr == smc_pkg::OFS_HALT_CMD && scr2_r[4:3] == 2'h0 |=> cpu_run_out;
    endproperty
    a_halt_refuse: assert property (p_halt_refuse) else $error("empty halt taken");
    property p_run_all;
        cpu_run_out |-> sys_clk_en_out && rtc_run_out && (&periph_run_out);
    endproperty
    a_run_all: assert property (p_run_all) else $error("run outputs wrong");
    property p_no_sysclk;
        !sys_clk_en_out |-> periph_run_out == '0;
    endproperty
    a_no_sysclk: assert property (p_no_sysclk) else $error("peripheral without clock");
    property p_stop_dead;
        !rtc_run_out |-> !cpu_run_out && !sys_clk_en_out && !osc_high_run_out && !osc_low_run_out;
    endproperty
    a_stop_dead: assert property (p_stop_dead) else $error("circuit alive in stop");
    property p_warm_hold;
        $rose(rtc_run_out) && !cpu_run_out |-> !cpu_run_out [*8];
    endproperty
    a_warm_hold: assert property (p_warm_hold) else $error("clock before warm-up");
    property p_warm_len;
        $rose(cpu_run_out) && from_stop_r |-> cnt_r >= exp_cnt && cnt_r <= exp_cnt + 16;
    endproperty
    a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong");
    property p_resume;
        $rose(cpu_run_out) && from_stop_r
            |-> {osc_low_run_out, osc_high_run_out, clk_low_sel_out} == scr0_r;
    endproperty
    a_resume: assert property (p_resume) else $error("resume clock wrong");
    property p_wake;
        !cpu_run_out && sys_clk_en_out && wake_req_in |-> ##[1:20] cpu_run_out;
    endproperty
    a_wake: assert property (p_wake) else $error("idle not released");
    property p_stop_float;
        !rtc_run_out && !scr2_r[2] |-> special_ie_out
            && {gen_oe_out, pu_oe_out, low_oe_out, gen_ie_out, pu_ie_out, low_ie_out} == '0;
    endproperty
    a_stop_float: assert property (p_stop_float) else $error("pins live in stop");
    property p_stop_drive;
        !rtc_run_out && scr2_r[2] |-> {gen_oe_out, pu_oe_out, low_oe_out}
            == $past({gen_dir_in, pu_dir_in, low_dir_in}) && {gen_ie_out, pu_ie_out} == '0
            && special_ie_out;
    endproperty
    a_stop_drive: assert property (p_stop_drive) else $error("pins wrong in stop");
    c_part_wake: cover property (!cpu_run_out && sys_clk_en_out && wake_req_in);
    c_stop_drive: cover property (!rtc_run_out && scr2_r[2]);
    c_low_resume: cover property ($rose(cpu_run_out) && from_stop_r && clk_low_sel_out);
endmodule
bind smc_top smc_top_sva #(.NPERIPH(NPERIPH), .NGEN(NGEN), .NPU(NPU), .NLOW(NLOW),
    .WARM_LEN_8(WARM_LEN_8), .WARM_LEN_14(WARM_LEN_14), .WARM_LEN_16(WARM_LEN_16),
    .WARM_LEN_18(WARM_LEN_18)) u_sva (.*);

//--- tb/smc_top_bench.sv
// Self-checking bench for the standby mode controller
`timescale 1ns/10ps
module smc_top_bench;
    // Short warm-up lengths keep each stop release brief
    localparam int W8 = 4;
    localparam int W14 = 16;
    localparam int W16 = 64;
    localparam int W18 = 256;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic wake_req_in = 1'b0;
    logic [7:0] gen_dir_in = 8'h3C;
    logic [3:0] pu_dir_in = 4'h5;
    logic [4:0] low_dir_in = 5'h0A;
    logic [31:0] prdata;
    logic pready, pslverr, cpu_run_out, sys_clk_en_out, osc_high_run_out, osc_low_run_out;
    logic rtc_run_out, clk_low_sel_out, special_ie_out;
    logic [7:0] periph_run_out, gen_oe_out, gen_ie_out;
    logic [3:0] pu_oe_out, pu_ie_out;
    logic [4:0] low_oe_out, low_ie_out;
    int errors = 0;
    int comparisons = 0;
    int n;
    int lens [4] = '{W18, W8, W14, W16};
    logic [31:0] q;
    logic e;

    always #4 clk_in = ~clk_in;

    smc_top #(.WARM_LEN_8(W8), .WARM_LEN_14(W14), .WARM_LEN_16(W16), .WARM_LEN_18(W18)) DUT (.*);

    ////////
    task automatic report_and_stop;
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        comparisons++;
        if (got !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, got);
        end
    endtask

    // One APB transfer; called just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
        if (k == 16) begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("prdata", x, q);
    endtask

    task automatic halt;
        apb(1'b1, smc_pkg::OFS_HALT_CMD, 32'h0);
        repeat (3) @(posedge clk_in);
    endtask

    // Wake held until the cpu runs; n counts cycles
    task automatic wake;
        wake_req_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (cpu_run_out !== 1'b1 && n < 3000);
        wake_req_in <= 1'b0;
        @(posedge clk_in);
        if (n == 3000) begin
            errors++;
            report_and_stop();
        end
    endtask

    ////////
    initial begin
        int x;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        rd(smc_pkg::OFS_SCR0, 32'h2);
        rd(smc_pkg::OFS_SCR2, 32'h2);
        rd(smc_pkg::OFS_IDLE_CFG, 32'h0);
        rd(smc_pkg::OFS_HALT_CMD, 32'h0);
        rd(smc_pkg::OFS_STATUS, 32'h41);
        rd(8'h14, 32'h0);
        chk("pslverr", 32'h1, e);
        halt();
        chk("cpu_run_out", 32'h1, cpu_run_out);
        apb(1'b1, smc_pkg::OFS_IDLE_CFG, 32'hA5);
        apb(1'b1, smc_pkg::OFS_SCR2, 32'h09);
        halt();
        chk("cpu_run_out", 32'h0, cpu_run_out);
        chk("sys_clk_en_out", 32'h1, sys_clk_en_out);
        chk("periph_run_out", 32'hA5, periph_run_out);
        rd(smc_pkg::OFS_STATUS, 32'h42);
        wake();
        chk("periph_run_out", 32'hFF, periph_run_out);
        apb(1'b1, smc_pkg::OFS_SCR2, 32'h11);
        halt();
        chk("sys_clk_en_out", 32'h0, sys_clk_en_out);
        chk("periph_run_out", 32'h0, periph_run_out);
        chk("osc_high_run_out", 32'h1, osc_high_run_out);
        chk("rtc_run_out", 32'h1, rtc_run_out);
        wake();
        chk("wake_cycles", 32'h1, n <= 20);
        // Every warm-up code, both drive settings, both resume clocks
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, smc_pkg::OFS_SCR0, i[1] ? 32'h5 : 32'h2);
            apb(1'b1, smc_pkg::OFS_SCR2, {27'h0, 2'h3, i[0], i[1:0]});
            halt();
            chk("rtc_run_out", 32'h0, rtc_run_out);
            chk("osc_high_run_out", 32'h0, osc_high_run_out);
            chk("osc_low_run_out", 32'h0, osc_low_run_out);
            chk("gen_oe_out", i[0] ? gen_dir_in : 8'h00, gen_oe_out);
            chk("gen_ie_out", 32'h0, gen_ie_out);
            chk("pu_oe_out", i[0] ? pu_dir_in : 4'h0, pu_oe_out);
            chk("pu_ie_out", 32'h0, pu_ie_out);
            chk("special_ie_out", 32'h1, special_ie_out);
            chk("low_oe_out", i[0] ? low_dir_in : 5'h00, low_oe_out);
            chk("low_ie_out", i[0] ? {~low_dir_in} : 5'h00, low_ie_out);
            x = lens[i] * (i[1] ? smc_pkg::LOW_DIV : smc_pkg::HIGH_DIV);
            wake();
            chk("warm_cycles", 32'h1, n >= x && n <= x + 20);
            chk("clk_low_sel_out", i[1], clk_low_sel_out);
            chk("osc_high_run_out", !i[1], osc_high_run_out);
        end
        report_and_stop();
    end
endmodule
